// File: hdl/jfp_prog_path.sv
`timescale 1ns/1ps

// What this block does
// - the instruction register is four bits and every chain shifts least significant bit first.
// - code 4 selects a 16-bit unlock chain that takes the signature during Shift-DR.
// - only the pattern 1010_0011_0111_0000 counts as a valid unlock signature.
// - on Update-DR of the unlock chain the value is compared and programming mode set on match.
// - code 5 selects the 15-bit command chain between TDI and TDO.
// - Capture-DR of the command chain loads the result of the previous command.
// - Shift-DR of the command chain sends the old result out while the new command comes in.
// - Update-DR of the command chain applies the new command to the flash control inputs only while programming mode is set.
// - entering Run-Test/Idle after a command produces one internal execute clock.
// - code 6 selects a 1024-bit virtual page-fill chain built on an 8-bit shifter.
// - the page-fill chain moves nothing on Update-DR and writes every full byte while shifting.
// - code 7 selects a 1032-bit virtual page-dump chain built on an 8-bit shifter.
// - the page-dump chain loads nothing on Capture-DR and fetches bytes while shifting.
// - the page-dump chain ignores TDI.
module jfp_prog_path
  import jfp_pkg::*;
#(
  parameter int unsigned PAGE_BITS_P = PAGE_BITS
)(
  // core clock and reset
  input  wire logic          mclk_i,
  input  wire logic          reset_n_i,
  // test access port pins
  input  wire logic          tck_i,
  input  wire logic          tms_i,
  input  wire logic          tdi_i,
  output logic               tdo_o,
  output logic               tdo_oe_n_o,
  // flash control side
  output logic               prog_mode_o,
  output logic [CMD_W-1:0]   flash_cmd_o,
  output logic               cmd_apply_o,
  output logic               cmd_exec_o,
  input  wire logic [CMD_W-1:0] cmd_result_i,
  input  wire logic          cmd_result_valid_i,
  // page buffer side
  output jfp_pbuf_wr_t       pbuf_wr_o,
  output jfp_pbuf_rd_t       pbuf_rd_o,
  input  wire logic [7:0]    pbuf_rd_data_i,
  input  wire logic          pbuf_rd_valid_i
);

  localparam int unsigned PAGE_BYTES = PAGE_BITS_P / BYTE_W;
  localparam logic [7:0]  LAST_IDX   = 8'(PAGE_BYTES - 1);

  // ==========================================================
  // link-side state, clocked by tck
  typedef struct packed {
    logic             rst_meta;
    logic             rst_sync;
    jfp_tap_t         tap;
    logic [3:0]       ir;
    logic [15:0]      dr;
    logic [2:0]       bitc;
    logic [7:0]       idx;
    logic             prog;
    logic [CMD_W-1:0] cmd;
    logic             cmd_tgl;
    logic             cmd_last;
    logic             exec_tgl;
    logic [7:0]       fill_data;
    logic [6:0]       fill_addr;
    logic             wr_tgl;
    logic [6:0]       rd_addr;
    logic             rd_tgl;
    logic [7:0]       rd_stage;
    logic             ack_meta;
    logic             ack_sync;
    logic             ack_seen;
    logic [CMD_W-1:0] res;
    logic             res_meta;
    logic             res_sync;
    logic             res_seen;
  } jfp_link_t;

  // ==========================================================
  // core-side state, clocked by mclk
  typedef struct packed {
    logic [3:0]       cmd_s;
    logic [3:0]       exec_s;
    logic [3:0]       wr_s;
    logic [3:0]       rd_s;
    logic [1:0]       prog_s;
    logic             prog;
    logic [CMD_W-1:0] flash_cmd;
    logic             apply;
    logic             exec;
    jfp_pbuf_wr_t     wr;
    jfp_pbuf_rd_t     rd;
    logic [7:0]       rd_hold;
    logic             ack_tgl;
    logic [CMD_W-1:0] res_hold;
    logic             res_tgl;
  } jfp_core_t;

  jfp_link_t lq, ld;
  jfp_core_t cq, cd;
  logic      tdo_r;
  logic      tdo_oe_n_r;

  // ==========================================================
  // link logic
  always_comb
  begin
    logic [7:0] byte_in;
    byte_in = {tdi_i, lq.dr[7:1]};
    ld = lq;
    ld.rst_meta = reset_n_i;
    ld.rst_sync = lq.rst_meta;
    ld.ack_meta = cq.ack_tgl;
    ld.ack_sync = lq.ack_meta;
    ld.ack_seen = lq.ack_sync;
    ld.res_meta = cq.res_tgl;
    ld.res_sync = lq.res_meta;
    ld.res_seen = lq.res_sync;
    // words from the core are stable long before their toggle is seen here
    if (lq.ack_sync != lq.ack_seen)
      ld.rd_stage = cq.rd_hold;
    if (lq.res_sync != lq.res_seen)
      ld.res = cq.res_hold;
    ld.tap = jfp_tap_next(lq.tap, tms_i);
    unique case (lq.tap)
      TAP_RESET:
      begin
        ld.ir       = IR_RESET_VAL;
        ld.cmd_last = 1'b0;
      end
      TAP_IDLE, TAP_SEL_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR,
      TAP_SEL_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR:
      begin
      end
      TAP_CAP_IR:
        ld.ir = IR_CAPTURE_VAL;
      TAP_SHIFT_IR:
        ld.ir = {tdi_i, lq.ir[3:1]};
      TAP_UPD_IR:
        ld.cmd_last = 1'b0;
      TAP_CAP_DR:
      begin
        ld.bitc = '0;
        ld.idx  = '0;
        unique case (lq.ir)
          COMMAND_ENTRY_INSTR:
            ld.dr = {1'b0, lq.res};
          PAGE_DUMP_INSTR:
          begin
            // chain itself is not loaded, only the first fetch is started
            ld.rd_addr = '0;
            ld.rd_tgl  = ~lq.rd_tgl;
          end
          default:
            ld.dr = DR_RESET_VAL;
        endcase
      end
      TAP_SHIFT_DR:
      begin
        ld.bitc = lq.bitc + 3'h1;
        unique case (lq.ir)
          UNLOCK_PROGRAMMING_INSTR:
            ld.dr = {tdi_i, lq.dr[15:1]};
          COMMAND_ENTRY_INSTR:
            ld.dr = {1'b0, tdi_i, lq.dr[CMD_W-1:1]};
          PAGE_FILL_INSTR:
          begin
            ld.dr = {8'h00, byte_in};
            if (lq.bitc == BIT_LAST && lq.idx <= LAST_IDX)
            begin
              ld.fill_data = byte_in;
              ld.fill_addr = lq.idx[6:0];
              ld.wr_tgl    = ~lq.wr_tgl;
              ld.idx       = lq.idx + 8'h01;
            end
          end
          PAGE_DUMP_INSTR:
          begin
            ld.dr = {9'h000, lq.dr[7:1]};
            if (lq.bitc == BIT_LAST)
            begin
              // the fetched byte becomes the next eight bits out
              ld.dr  = {8'h00, lq.rd_stage};
              ld.idx = lq.idx + 8'h01;
              if (lq.idx < LAST_IDX)
              begin
                ld.rd_addr = 7'(lq.idx + 8'h01);
                ld.rd_tgl  = ~lq.rd_tgl;
              end
            end
          end
          default:
            ld.dr = {15'h0000, tdi_i};
        endcase
      end
      TAP_UPD_DR:
      begin
        ld.cmd_last = 1'b0;
        unique case (lq.ir)
          UNLOCK_PROGRAMMING_INSTR:
            ld.prog = (lq.dr == UNLOCK_SIG);
          COMMAND_ENTRY_INSTR:
          begin
            if (lq.prog)
            begin
              ld.cmd      = lq.dr[CMD_W-1:0];
              ld.cmd_tgl  = ~lq.cmd_tgl;
              ld.cmd_last = 1'b1;
            end
          end
          default:
          begin
          end
        endcase
      end
    endcase
    // execute clock only on the entry into run-test/idle after a command
    if (lq.tap == TAP_UPD_DR && !tms_i && lq.cmd_last)
      ld.exec_tgl = ~lq.exec_tgl;
    if (lq.tap == TAP_UPD_DR && !tms_i && lq.ir == COMMAND_ENTRY_INSTR && lq.prog)
      ld.exec_tgl = ~lq.exec_tgl;
    if (!lq.rst_sync)
    begin
      ld.tap       = TAP_RESET;
      ld.ir        = IR_RESET_VAL;
      ld.dr        = DR_RESET_VAL;
      ld.bitc      = '0;
      ld.idx       = '0;
      ld.prog      = 1'b0;
      ld.cmd       = CMD_RESET_VAL;
      ld.cmd_tgl   = 1'b0;
      ld.cmd_last  = 1'b0;
      ld.exec_tgl  = 1'b0;
      ld.fill_data = '0;
      ld.fill_addr = '0;
      ld.wr_tgl    = 1'b0;
      ld.rd_addr   = '0;
      ld.rd_tgl    = 1'b0;
      ld.rd_stage  = '0;
      ld.res       = CMD_RESET_VAL;
    end
  end

  always_ff @(posedge tck_i)
  begin
    lq <= ld;
  end

  // tdo changes on the falling edge so the host can sample on the rising one
  always_ff @(negedge tck_i)
  begin
    tdo_r      <= (lq.tap == TAP_SHIFT_IR) ? lq.ir[0] : lq.dr[0];
    tdo_oe_n_r <= !(lq.tap == TAP_SHIFT_IR || lq.tap == TAP_SHIFT_DR);
  end

  // ==========================================================
  // core logic: toggles cross by three flops, words are held on the far side
  always_comb
  begin
    cd = cq;
    cd.cmd_s  = {cq.cmd_s[2:0], lq.cmd_tgl};
    cd.exec_s = {cq.exec_s[2:0], lq.exec_tgl};
    cd.wr_s   = {cq.wr_s[2:0], lq.wr_tgl};
    cd.rd_s   = {cq.rd_s[2:0], lq.rd_tgl};
    cd.prog_s = {cq.prog_s[0], lq.prog};
    cd.prog   = cq.prog_s[1];
    cd.apply  = cq.cmd_s[2] ^ cq.cmd_s[3];
    cd.exec   = cq.exec_s[2] ^ cq.exec_s[3];
    if (cq.cmd_s[2] ^ cq.cmd_s[3])
      cd.flash_cmd = lq.cmd;
    cd.wr.valid = cq.wr_s[2] ^ cq.wr_s[3];
    cd.wr.addr  = lq.fill_addr;
    cd.wr.data  = lq.fill_data;
    cd.rd.valid = cq.rd_s[2] ^ cq.rd_s[3];
    cd.rd.addr  = lq.rd_addr;
    if (pbuf_rd_valid_i)
    begin
      cd.rd_hold = pbuf_rd_data_i;
      cd.ack_tgl = ~cq.ack_tgl;
    end
    if (cmd_result_valid_i)
    begin
      cd.res_hold = cmd_result_i;
      cd.res_tgl  = ~cq.res_tgl;
    end
    if (!reset_n_i)
    begin
      cd.prog      = 1'b0;
      cd.flash_cmd = CMD_RESET_VAL;
      cd.apply     = 1'b0;
      cd.exec      = 1'b0;
      cd.wr        = '0;
      cd.rd        = '0;
      cd.rd_hold   = '0;
      cd.ack_tgl   = 1'b0;
      cd.res_hold  = CMD_RESET_VAL;
      cd.res_tgl   = 1'b0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    cq <= cd;
  end

  // ==========================================================
  // outputs
  assign tdo_o       = tdo_r;
  assign tdo_oe_n_o  = tdo_oe_n_r;
  assign prog_mode_o = cq.prog;
  assign flash_cmd_o = cq.flash_cmd;
  assign cmd_apply_o = cq.apply;
  assign cmd_exec_o  = cq.exec;
  assign pbuf_wr_o   = cq.wr;
  assign pbuf_rd_o   = cq.rd;

endmodule : jfp_prog_path

// File: shared/jfp_pkg.sv
package jfp_pkg;

  // ==========================================================
  // instruction register and codes
  localparam int unsigned IR_W                  = 4;
  localparam logic [3:0]  UNLOCK_PROGRAMMING_INSTR = 4'h4;
  localparam logic [3:0]  COMMAND_ENTRY_INSTR   = 4'h5;
  localparam logic [3:0]  PAGE_FILL_INSTR       = 4'h6;
  localparam logic [3:0]  PAGE_DUMP_INSTR       = 4'h7;
  localparam logic [3:0]  IR_RESET_VAL          = 4'hF;
  localparam logic [3:0]  IR_CAPTURE_VAL        = 4'h1;

  // ==========================================================
  // data register sizes and values
  localparam int unsigned UNLOCK_W       = 16;
  localparam int unsigned CMD_W          = 15;
  localparam int unsigned BYTE_W         = 8;
  localparam int unsigned PAGE_BITS      = 1024;
  localparam int unsigned DUMP_EXTRA     = 8;
  localparam logic [15:0] UNLOCK_SIG     = 16'hA370;
  localparam logic [15:0] DR_RESET_VAL   = 16'h0000;
  localparam logic [14:0] CMD_RESET_VAL  = 15'h0000;
  localparam logic [2:0]  BIT_LAST       = 3'h7;

  // ==========================================================
  // test access port states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
    TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jfp_tap_t;

  // ==========================================================
  // carriers towards the flash side
  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
    logic [7:0] data;
  } jfp_pbuf_wr_t;

  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
  } jfp_pbuf_rd_t;

  function automatic jfp_tap_t jfp_tap_next(input jfp_tap_t s, input logic tms);
    unique case (s)
      TAP_RESET:    return tms ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     return tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   return tms ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   return tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: return tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: return tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: return tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: return tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   return tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   return tms ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   return tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: return tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: return tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: return tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: return tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   return tms ? TAP_SEL_DR   : TAP_IDLE;
    endcase
  endfunction : jfp_tap_next

endpackage : jfp_pkg

// File: dv/jfp_prog_path_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// port checker, core clock domain only
module jfp_prog_path_checker
  import jfp_pkg::*;
#(
  parameter int unsigned PAGE_BITS_P = PAGE_BITS
)(
  // core clock and reset
  input wire logic         mclk_i,
  input wire logic         reset_n_i,
  // flash control side
  input wire logic         prog_mode_o,
  input wire logic [14:0]  flash_cmd_o,
  input wire logic         cmd_apply_o,
  input wire logic         cmd_exec_o,
  // page buffer side
  input wire jfp_pbuf_wr_t pbuf_wr_o,
  input wire jfp_pbuf_rd_t pbuf_rd_o
);
  logic [6:0] wr_last_r;
  logic [6:0] rd_last_r;

  // last byte addresses, so ordering can be judged across a whole scan
  always_ff @(posedge mclk_i)
  begin
    if (pbuf_wr_o.valid)
      wr_last_r <= pbuf_wr_o.addr;
    if (pbuf_rd_o.valid)
      rd_last_r <= pbuf_rd_o.addr;
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  // bytes come eight tck apart, far more than eight core cycles
  sequence s_wr_quiet;
    !pbuf_wr_o.valid [*8];
  endsequence
  sequence s_rd_quiet;
    !pbuf_rd_o.valid [*8];
  endsequence

  apply_pulse_a: assert property (cmd_apply_o |=> !cmd_apply_o)
    else $error("apply pulse too long");
  exec_pulse_a: assert property (cmd_exec_o |=> !cmd_exec_o)
    else $error("execute pulse too long");
  apply_gate_a: assert property (cmd_apply_o |-> prog_mode_o)
    else $error("command applied while locked");
  exec_gate_a: assert property (cmd_exec_o |-> prog_mode_o)
    else $error("command executed while locked");
  cmd_hold_a: assert property ($changed(flash_cmd_o) |-> cmd_apply_o)
    else $error("command changed without apply");
  wr_gap_a: assert property (pbuf_wr_o.valid |=> s_wr_quiet)
    else $error("page writes too close");
  wr_order_a: assert property (pbuf_wr_o.valid |-> pbuf_wr_o.addr == 7'h00 ||
    pbuf_wr_o.addr == wr_last_r + 7'h01) else $error("page write out of order");
  rd_gap_a: assert property (pbuf_rd_o.valid |=> s_rd_quiet)
    else $error("page reads too close");
  rd_order_a: assert property (pbuf_rd_o.valid |-> pbuf_rd_o.addr == 7'h00 ||
    pbuf_rd_o.addr == rd_last_r + 7'h01) else $error("page read out of order");
endmodule : jfp_prog_path_checker

bind jfp_prog_path jfp_prog_path_checker #(.PAGE_BITS_P(PAGE_BITS_P)) u_chk (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .prog_mode_o(prog_mode_o),
  .flash_cmd_o(flash_cmd_o), .cmd_apply_o(cmd_apply_o), .cmd_exec_o(cmd_exec_o),
  .pbuf_wr_o(pbuf_wr_o), .pbuf_rd_o(pbuf_rd_o));

// File: dv/jfp_jtag_host.sv
`timescale 1ns/1ps
// ==========================================================
// test access port host; tck stands low between frames
module jfp_jtag_host
(
  // link pins
  output logic      tck_o = 1'b0,
  output logic      tms_o = 1'b1,
  output logic      tdi_o = 1'b0,
  input  wire logic tdo_i
);
  logic [1039:0] dout;

  // inputs move after the falling edge, tdo is taken at the rising edge
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #80;
    tck_o = 1'b1;
    tdo = tdo_i;
    #80;
    tck_o = 1'b0;
  endtask : step

  task automatic reset_walk;
    logic b;
    repeat (5) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask : reset_walk

  // one scan from Run-Test/Idle back to Run-Test/Idle
  task automatic scan(input logic ir, input int n, input logic [1039:0] din);
    logic b;
    step(1'b1, 1'b0, b);
    if (ir)
      step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    // released line must not keep showing the last bit
    tdi_o = ~tdi_o;
  endtask : scan
endmodule : jfp_jtag_host

// File: dv/jfp_prog_path_tb.sv
`timescale 1ns/1ps
// ==========================================================
// bench top
module jfp_prog_path_tb
  import jfp_pkg::*;
;
  logic         mclk_i = 1'b0;
  logic         reset_n_i = 1'b0;
  logic         tck, tms, tdi, tdo, tdo_oe_n, prog_mode, apply, exec;
  logic [14:0]  cmd_result_i = 15'h0000;
  logic         cmd_result_valid_i = 1'b0;
  logic [7:0]   pbuf_rd_data_i = 8'h00;
  logic         pbuf_rd_valid_i = 1'b0;
  logic [14:0]  flash_cmd, last_cmd;
  jfp_pbuf_wr_t wr;
  jfp_pbuf_rd_t rd;
  logic [14:0]  wr_q[$];
  int           bad_count, check_count, apply_n, exec_n;
  wire          tdo_w = (tdo_oe_n === 1'b0) ? tdo : 1'bz;

  always #2 mclk_i = ~mclk_i;

  jfp_prog_path #(.PAGE_BITS_P(PAGE_BITS)) u_dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .prog_mode_o(prog_mode), .flash_cmd_o(flash_cmd),
    .cmd_apply_o(apply), .cmd_exec_o(exec), .cmd_result_i(cmd_result_i),
    .cmd_result_valid_i(cmd_result_valid_i), .pbuf_wr_o(wr), .pbuf_rd_o(rd),
    .pbuf_rd_data_i(pbuf_rd_data_i), .pbuf_rd_valid_i(pbuf_rd_valid_i));

  jfp_jtag_host u_host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_w));

  function automatic logic [7:0] page_byte(input logic [6:0] a);
    return 8'hC3 ^ {1'b0, a};
  endfunction : page_byte

  // ==========================================================
  // flash side: answers reads one cycle later, logs writes and pulses
  always @(posedge mclk_i)
  begin
    pbuf_rd_valid_i <= rd.valid === 1'b1;
    pbuf_rd_data_i <= (rd.valid === 1'b1) ? page_byte(rd.addr) : ~pbuf_rd_data_i;
    if (wr.valid === 1'b1)
      wr_q.push_back({wr.addr, wr.data});
    if (apply === 1'b1)
      last_cmd = flash_cmd;
    apply_n += int'(apply === 1'b1);
    exec_n += int'(exec === 1'b1);
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic ir(input logic [3:0] c);
    u_host.scan(1'b1, 4, {1036'h0, c});
    chk(16'(u_host.dout[3:0]), 16'(IR_CAPTURE_VAL));
  endtask : ir

  // ==========================================================
  // scenarios
  task automatic t_refuse;
    // reset instruction leaves a one-bit bypass chain
    u_host.scan(1'b0, 2, {1038'h0, 2'b01});
    chk(16'(u_host.dout[1:0]), 16'h0002);
    ir(UNLOCK_PROGRAMMING_INSTR);
    u_host.scan(1'b0, 16, {1024'h0, UNLOCK_SIG ^ 16'h0001});
    repeat (4) @(posedge mclk_i);
    chk(16'(prog_mode), 16'h0000);
    ir(COMMAND_ENTRY_INSTR);
    u_host.scan(1'b0, 15, {1025'h0, 15'h1234});
    repeat (4) @(posedge mclk_i);
    chk(16'(apply_n + exec_n), 16'h0000);
    $display("refuse test done");
  endtask : t_refuse

  task automatic t_unlock;
    ir(UNLOCK_PROGRAMMING_INSTR);
    u_host.scan(1'b0, 16, {1024'h0, UNLOCK_SIG});
    repeat (4) @(posedge mclk_i);
    chk(16'(prog_mode), 16'h0001);
    chk(16'(tdo_oe_n), 16'h0001);
    $display("unlock test done");
  endtask : t_unlock

  task automatic t_command;
    cmd_result_i <= 15'h5A3C;
    cmd_result_valid_i <= 1'b1;
    @(posedge mclk_i);
    cmd_result_valid_i <= 1'b0;
    ir(COMMAND_ENTRY_INSTR);
    u_host.scan(1'b0, 15, {1025'h0, 15'h1234});
    repeat (4) @(posedge mclk_i);
    chk(16'(u_host.dout[14:0]), 16'h5A3C);
    chk(16'(last_cmd), 16'h1234);
    chk(16'(apply_n), 16'h0001);
    chk(16'(exec_n), 16'h0001);
    $display("command test done");
  endtask : t_command

  task automatic t_fill;
    logic [23:0] d;
    d = 24'h0B5AE1;
    ir(PAGE_FILL_INSTR);
    u_host.scan(1'b0, 24, {1016'h0, d});
    repeat (4) @(posedge mclk_i);
    chk(16'(wr_q.size()), 16'h0003);
    for (int i = 0; i < 3; i++)
      chk(16'(wr_q[i]), 16'({7'(i), d[8*i +: 8]}));
    $display("fill test done");
  endtask : t_fill

  task automatic t_dump;
    // tdi held high all scan long must not reach tdo
    ir(PAGE_DUMP_INSTR);
    u_host.scan(1'b0, 32, {1008'h0, 32'hFFFF_FFFF});
    for (int i = 0; i < 3; i++)
      chk(16'(u_host.dout[8 + 8*i +: 8]), 16'(page_byte(7'(i))));
    $display("dump test done");
  endtask : t_dump

  // ==========================================================
  // run control
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (3) @(posedge mclk_i);
    // tck side reset needs tck edges while reset is low
    u_host.reset_walk();
    @(posedge mclk_i);
    reset_n_i <= 1'b1;
    u_host.reset_walk();
    t_refuse();
    t_unlock();
    t_command();
    t_fill();
    t_dump();
    tally_and_finish();
  end

  // about 230 tck of traffic is 37 us; allow five times that
  initial
  begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
endmodule : jfp_prog_path_tb
